// ### rtl/psbm_pkg.sv
// Constants and types shared by the bus-state and power-mode controller.
package psbm_pkg;

    // Core clock rate in MHz.
    localparam int CLK_MHZ          = 50;
    // Read access time and the margin before clock stop, in ns.
    localparam int ACCESS_TIME_NS   = 35;
    localparam int STOP_MARGIN_NS   = 30;
    // Least idle time before clock stop, rounded up to cycles.
    localparam int STOP_CYC = ((ACCESS_TIME_NS + STOP_MARGIN_NS) * CLK_MHZ
                               + 999) / 1000;
    // Longest sleep and power-down entry times in us, rounded down.
    localparam int SLEEP_ENTRY_US   = 3;
    localparam int SLEEP_ENTRY_CYC  = SLEEP_ENTRY_US * CLK_MHZ;
    localparam int PDOWN_ENTRY_US   = 3;
    localparam int PDOWN_ENTRY_CYC  = PDOWN_ENTRY_US * CLK_MHZ;
    // Longest wakeup times in us and their cycle counts.
    localparam int SLEEP_WAKEUP_US  = 100;
    localparam int SLEEP_WAKEUP_CYC = SLEEP_WAKEUP_US * CLK_MHZ;
    localparam int PDOWN_WAKEUP_US  = 150;
    localparam int PDOWN_WAKEUP_CYC = PDOWN_WAKEUP_US * CLK_MHZ;
    // Command/address phase length in clock edges and default latency.
    localparam int CA_EDGES         = 6;
    localparam int LAT_CLKS         = 6;
    // Command bits inside the first command byte.
    localparam int CA_READ_BIT      = 47;
    localparam int CA_REG_BIT       = 46;
    // Width of the long timing counters.
    localparam int TCNT_W           = 13;

    // Bus phase of the current transaction.
    typedef enum logic [3:0] {
        X_STBY = 4'h1,
        X_CA   = 4'h2,
        X_LAT  = 4'h4,
        X_DATA = 4'h8
    } psbm_phase_e;

    // Power mode of the device.
    typedef enum logic [6:0] {
        P_ON        = 7'h01,
        P_SLEEP_IN  = 7'h02,
        P_SLEEP     = 7'h04,
        P_SLEEP_OUT = 7'h08,
        P_PDOWN_IN  = 7'h10,
        P_PDOWN     = 7'h20,
        P_PDOWN_OUT = 7'h40
    } psbm_power_e;

endpackage

// ### rtl/psbm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module psbm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Full and empty come straight from the fill count.
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage array.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// ### rtl/psbm_ctrl.sv
// Bus-state and power-mode controller of a DDR pseudo-static DRAM.
// Behaviour
// [R01] Chip select high: standby, ignore other pins.
// [R02] Write latency: DQ and strobe undriven.
// [R03] Host drives write data, strobe as mask.
// [R04] Device drives strobe during command phase.
// [R05] Zero-latency write: strobe released after command.
// [R06] Zero-latency write stores all bytes unmasked.
// [R07] Host pauses clock only at low level.
// [R08] Clock idle past access time: clock stop.
// [R09] Clock stop holds read data on DQ.
// [R10] Host ends select before maximum low time.
// [R11] Host avoids clock stop on register access.
// [R12] Sleep request reaches sleep within 3 us.
// [R13] Sleep keeps array and register contents.
// [R14] Select low wakes sleep, clears request bit.
// [R15] Host wake pulse 60 to 3000 ns.
// [R16] Reset also ends sleep, refresh stops.
// [R17] Sleep exit reaches standby within 100 us.
// [R18] Power-down write reaches lowest power, 3 us.
// [R19] Power-down loses array contents.
// [R20] Host power-down exit pulse 200-3000 ns.
// [R21] Reset also ends power-down.
// [R22] Power-down exit: standby, default registers.
// [R23] Low-power states take select only as wake.
`timescale 1ns/100ps
`default_nettype none
module psbm_ctrl
    import psbm_pkg::*;
#(
    parameter int LATENCY_CLKS  = LAT_CLKS,
    parameter int SLEEP_WAKE    = SLEEP_WAKEUP_CYC,
    parameter int PDOWN_WAKE    = PDOWN_WAKEUP_CYC,
    parameter int FIFO_DEPTH    = 32
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       cs_n_pin,
    input  wire logic       ck_pin,
    input  wire logic       reset_n_pin,
    input  wire logic [7:0] dq_in,
    output logic      [7:0] dq_out,
    output logic            dq_oe,
    input  wire logic       rwds_in,
    output logic            rwds_out,
    output logic            rwds_oe,
    input  wire logic       refresh_busy,
    input  wire logic       sleep_set,
    input  wire logic       pdown_set,
    input  wire logic [7:0] rd_data,
    output logic            rd_req,
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic      [7:0] wr_data,
    output logic            wr_mask,
    output logic            wr_overrun,
    output logic     [47:0] ca_word,
    output logic            ca_valid,
    output logic            sleep_bit,
    output logic            low_power,
    output logic            refresh_en,
    output logic            array_lost,
    output logic            cfg_defaults,
    output logic            clock_stop,
    output logic            standby
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0]      ck_s;
    logic [1:0]      cs_s;
    logic            cs_d;
    logic [1:0]      rstn_s;
    logic [7:0]      dq_s1;
    logic [7:0]      dq_s2;
    logic [1:0]      rwds_s;
    logic            rst_all;
    logic            ck_edge;
    logic            cs_fall;
    logic            cs_rise;
    psbm_phase_e     ph;
    psbm_power_e     pwr;
    logic [5:0]      ecnt;
    logic            is_read;
    logic            zero_lat;
    logic            lat_dbl;
    logic [47:0]     next_ca;
    logic [2:0]      idle_cnt;
    logic [TCNT_W-1:0] tcnt;
    logic            pd_seen_low;
    logic            allow;
    logic            push;
    logic            push_mask;
    logic            fifo_in_ready;

    // Pin synchronisers; the second stage feeds logic, and a third stage gives the clock and select edges.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ck_s   <= 3'h0;
            cs_s   <= 2'h3;
            cs_d   <= 1'b1;
            rstn_s <= 2'h0;
            dq_s1  <= 8'h00;
            dq_s2  <= 8'h00;
            rwds_s <= 2'h0;
        end else begin
            ck_s   <= {ck_s[1:0], ck_pin};
            cs_s   <= {cs_s[0], cs_n_pin};
            cs_d   <= cs_s[1];
            rstn_s <= {rstn_s[0], reset_n_pin};
            dq_s1  <= dq_in;
            dq_s2  <= dq_s1;
            rwds_s <= {rwds_s[0], rwds_in};
        end
    end

    // The reset pin acts like the core reset on all control state.
    assign rst_all = rst || !rstn_s[1];                  // [R16] [R21]
    assign ck_edge = ck_s[2] ^ ck_s[1];
    assign cs_fall = cs_d && !cs_s[1];
    assign cs_rise = !cs_d && cs_s[1];
    assign allow   = (pwr == P_ON);
    assign next_ca = {ca_word[39:0], dq_s2};

    ////////////////////////////////////////////////////////////////////////
    // Transaction phase machine; select high returns it to standby.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            ph       <= X_STBY;
            ecnt     <= 6'h00;
            is_read  <= 1'b0;
            zero_lat <= 1'b0;
            lat_dbl  <= 1'b0;
            ca_word  <= 48'h000000000000;
            ca_valid <= 1'b0;
        end else begin
            ca_valid <= 1'b0;
            if (cs_s[1] || !allow) begin
                ph <= X_STBY;                            // [R01] [R23]
            end else begin
                case (ph)
                    X_STBY: begin
                        ph      <= X_CA;
                        ecnt    <= 6'h00;
                        lat_dbl <= refresh_busy;
                    end
                    X_CA: if (ck_edge) begin
                        ca_word <= next_ca;
                        ecnt    <= ecnt + 6'h01;
                        if (ecnt == 6'(CA_EDGES - 1)) begin
                            ca_valid <= 1'b1;
                            ecnt     <= 6'h00;
                            is_read  <= next_ca[CA_READ_BIT];
                            zero_lat <= !next_ca[CA_READ_BIT]
                                        && next_ca[CA_REG_BIT];
                            ph <= (!next_ca[CA_READ_BIT]
                                   && next_ca[CA_REG_BIT]) ? X_DATA
                                                           : X_LAT;
                        end
                    end
                    X_LAT: if (ck_edge) begin
                        ecnt <= ecnt + 6'h01;
                        if (ecnt == lat_last(lat_dbl)) begin
                            ph <= X_DATA;
                        end
                    end
                    X_DATA: ph <= X_DATA;
                    default: ph <= X_STBY;
                endcase
            end
        end
    end

    // Last latency edge index; a busy refresh doubles the latency.
    function automatic logic [5:0] lat_last(input logic dbl);
        lat_last = dbl ? 6'(4 * LATENCY_CLKS - 1)
                       : 6'(2 * LATENCY_CLKS - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Strobe: latency flag in command phase, read strobe afterwards.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            rwds_out <= 1'b0;
        end else if (ph == X_STBY) begin
            rwds_out <= refresh_busy;                    // [R04]
        end else if (ph == X_DATA && is_read && ck_edge) begin
            rwds_out <= !rwds_out;
        end else if (ph == X_LAT) begin
            rwds_out <= 1'b0;
        end
    end

    // Drive enables; write latency and zero-latency data are released.
    assign rwds_oe = (ph == X_CA)                        // [R04]
                     || ((ph == X_LAT || ph == X_DATA)
                         && is_read);                    // [R02] [R05]
    assign dq_oe   = (ph == X_DATA) && is_read;          // [R02]

    // Read data is loaded only on clock edges and so holds when it stops.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            dq_out <= 8'h00;
            rd_req <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            if (ph == X_DATA && is_read && ck_edge) begin
                dq_out <= rd_data;                       // [R09]
                rd_req <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write bytes go to the buffer; zero-latency writes are unmasked.
    assign push      = (ph == X_DATA) && !is_read && ck_edge;
    assign push_mask = zero_lat ? 1'b0 : rwds_s[1];      // [R03] [R06]

    // Full buffer drops the byte and reports the overrun.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            wr_overrun <= 1'b0;
        end else begin
            wr_overrun <= push && !fifo_in_ready;
        end
    end

    psbm_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk  (core_clk),
        .rst       (rst_all),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({push_mask, dq_s2}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_mask, wr_data})
    );

    ////////////////////////////////////////////////////////////////////////
    // Idle cycles since the last clock edge during data transfer.
    always_ff @(posedge core_clk) begin
        if (rst_all || ph != X_DATA || ck_edge) begin
            idle_cnt <= 3'h0;
        end else if (idle_cnt != 3'(STOP_CYC)) begin
            idle_cnt <= idle_cnt + 3'h1;
        end
    end
    assign clock_stop = (idle_cnt == 3'(STOP_CYC));      // [R08]

    ////////////////////////////////////////////////////////////////////////
    // Power mode machine with entry and wakeup timers.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            pwr         <= P_ON;
            tcnt        <= '0;
            pd_seen_low <= 1'b0;
        end else begin
            tcnt <= tcnt + 1'b1;
            case (pwr)
                P_ON: begin
                    tcnt <= '0;
                    if (pdown_set) begin
                        pwr <= P_PDOWN_IN;
                    end else if (sleep_set) begin
                        pwr <= P_SLEEP_IN;
                    end
                end
                P_SLEEP_IN: begin
                    if (tcnt == TCNT_W'(SLEEP_ENTRY_CYC - 2)) begin
                        pwr <= P_SLEEP;                  // [R12]
                    end
                end
                P_SLEEP: begin
                    tcnt <= '0;
                    if (cs_fall) begin
                        pwr <= P_SLEEP_OUT;              // [R14]
                    end
                end
                P_SLEEP_OUT: begin
                    if (tcnt == TCNT_W'(SLEEP_WAKE - 1)) begin
                        pwr <= P_ON;                     // [R17]
                    end
                end
                P_PDOWN_IN: begin
                    if (tcnt == TCNT_W'(PDOWN_ENTRY_CYC - 2)) begin
                        pwr         <= P_PDOWN;          // [R18]
                        pd_seen_low <= 1'b0;
                    end
                end
                P_PDOWN: begin
                    tcnt <= '0;
                    if (cs_fall) begin
                        pd_seen_low <= 1'b1;
                    end
                    if (cs_rise && pd_seen_low) begin
                        pwr <= P_PDOWN_OUT;              // [R23]
                    end
                end
                P_PDOWN_OUT: begin
                    if (tcnt == TCNT_W'(PDOWN_WAKE - 1)) begin
                        pwr <= P_ON;                     // [R22]
                    end
                end
                default: pwr <= P_ON;
            endcase
        end
    end

    // Sleep request bit; the wake event clears it.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            sleep_bit <= 1'b0;
        end else if (pwr == P_SLEEP && cs_fall) begin
            sleep_bit <= 1'b0;                           // [R14]
        end else if (allow && sleep_set) begin
            sleep_bit <= 1'b1;
        end
    end

    // Status of refresh, contents and register defaults.
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            refresh_en   <= 1'b0;
            array_lost   <= 1'b1;
            cfg_defaults <= 1'b1;
        end else begin
            refresh_en   <= (pwr != P_PDOWN) && (pwr != P_PDOWN_IN);
            cfg_defaults <= (pwr == P_PDOWN_OUT)
                            && (tcnt == TCNT_W'(PDOWN_WAKE - 1));
            if (pwr == P_PDOWN) begin                    // [R13]
                array_lost <= 1'b1;                      // [R19]
            end else if (ph == X_DATA && !is_read) begin
                array_lost <= 1'b0;
            end
        end
    end

    assign low_power = (pwr == P_SLEEP) || (pwr == P_PDOWN);
    assign standby   = allow && (ph == X_STBY);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst_all);

    property p_standby_quiet;
        cs_s[1] |=> !dq_oe && !rwds_oe;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) // [R01]
        else $error("Pins driven while deselected.");

    property p_wlat_release;
        (ph == X_LAT) && !is_read |-> !dq_oe && !rwds_oe;
    endproperty
    a_wlat_release: assert property (p_wlat_release) // [R02]
        else $error("Pins driven in write latency.");

    property p_ca_drive;
        $rose(ph == X_CA) |-> rwds_oe && (rwds_out == $past(refresh_busy));
    endproperty
    a_ca_drive: assert property (p_ca_drive) // [R04]
        else $error("Latency flag not driven in command phase.");

    property p_zl_release;
        (ph == X_DATA) && zero_lat |-> !rwds_oe && !dq_oe;
    endproperty
    a_zl_release: assert property (p_zl_release) // [R05]
        else $error("Strobe driven in zero-latency write.");

    property p_zl_nomask;
        push && zero_lat |-> !push_mask;
    endproperty
    a_zl_nomask: assert property (p_zl_nomask) // [R06]
        else $error("Zero-latency write byte masked.");

    property p_clock_stop;
        ((ph == X_DATA) && !ck_edge)[*4] ##1 (ph == X_DATA) |-> clock_stop;
    endproperty
    a_clock_stop: assert property (p_clock_stop) // [R08]
        else $error("Clock stop not entered.");

    property p_read_hold;
        dq_oe && !ck_edge |=> $stable(dq_out);
    endproperty
    a_read_hold: assert property (p_read_hold) // [R09]
        else $error("Read data changed without clock edge.");

    property p_sleep_entry;
        allow && sleep_set && !pdown_set |-> ##[1:150] (pwr == P_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) // [R12]
        else $error("Sleep not reached in time.");

    property p_wake_clear;
        (pwr == P_SLEEP) && cs_fall |=> !sleep_bit && (pwr == P_SLEEP_OUT);
    endproperty
    a_wake_clear: assert property (p_wake_clear) // [R14]
        else $error("Wake did not clear sleep request.");

    property p_no_cmd;
        low_power |-> (ph == X_STBY) && !ca_valid;
    endproperty
    a_no_cmd: assert property (p_no_cmd) // [R23]
        else $error("Command taken in low power.");

    property p_pdown_lost;
        (pwr == P_PDOWN) |=> array_lost && !refresh_en;
    endproperty
    a_pdown_lost: assert property (p_pdown_lost) // [R19]
        else $error("Power-down kept refresh running.");

    property p_pdown_defaults;
        ($past(pwr) == P_PDOWN_OUT) && (pwr == P_ON) |-> cfg_defaults;
    endproperty
    a_pdown_defaults: assert property (p_pdown_defaults) // [R22]
        else $error("Defaults not restored after power-down.");

    c_read: cover property (dq_oe && clock_stop);
    c_zl_write: cover property (push && zero_lat);
    c_sleep_wake: cover property ((pwr == P_SLEEP_OUT) ##1 (pwr == P_ON));
    c_pdown_exit: cover property (cfg_defaults);
endmodule
`default_nettype wire

// ### dv/psbm_host.sv
// Host controller model driving select, link clock, data and strobe.
`timescale 1ns/100ps
`default_nettype none
module psbm_host (
    input  wire logic       core_clk,
    output logic            cs_n_pin,
    output logic            ck_pin,
    output logic      [7:0] h_dq,
    output logic            h_rwds
);
    ////////////////////////////////////////////////////////////////////
    // Idle bus: deselected and the clock parked at its low level.
    initial begin
        cs_n_pin = 1'b1;
        ck_pin = 1'b0;
        h_dq = 8'h00;
        h_rwds = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // Drops select and leaves the sync time before the first edge.
    task automatic sel();
        @(negedge core_clk) cs_n_pin <= 1'b0;
        repeat (5) @(negedge core_clk);
    endtask
    // Ends the frame well inside the longest select low time.
    task automatic desel();
        repeat (4) @(negedge core_clk);
        cs_n_pin <= 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
    // Select pulse of n core cycles that only wakes the device.
    task automatic pulse(input int n);
        @(negedge core_clk) cs_n_pin <= 1'b0;
        repeat (n) @(negedge core_clk);
        cs_n_pin <= 1'b1;
        repeat (2) @(negedge core_clk);
    endtask
    // One link clock edge; a released line shows a changing value.
    task automatic edge_b(input logic [7:0] b, input logic m,
                          input logic dqd, input logic rwd);
        @(negedge core_clk);
        h_dq <= dqd ? b : ~h_dq;
        h_rwds <= rwd ? m : ~h_rwds;
        repeat (2) @(negedge core_clk);
        ck_pin <= ~ck_pin;
        @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ### dv/psbm_ctrl_test.sv
// Testbench of the bus-state and power-mode controller.
`timescale 1ns/100ps
`default_nettype none
module psbm_ctrl_test
    import psbm_pkg::*;
;
    logic        core_clk, rst, reset_n_pin, refresh_busy;
    logic        sleep_set, pdown_set, wr_ready, cs_n_pin, ck_pin;
    logic  [7:0] rd_data, dq_out, wr_data, h_dq;
    logic        h_rwds, dq_oe, rwds_out, rwds_oe, rd_req;
    logic        wr_valid, wr_mask, wr_overrun, ca_valid;
    logic        sleep_bit, low_power, refresh_en, array_lost;
    logic        cfg_defaults, clock_stop, standby;
    logic [47:0] ca_word;
    wire   [7:0] dq_in;
    wire         rwds_in;
    int          n_errors, n_compared, n_ca, n_ovr, n_rd, cyc;

    // Each shared pin shows whichever side drives it.
    assign dq_in = dq_oe ? dq_out : h_dq;
    assign rwds_in = rwds_oe ? rwds_out : h_rwds;

    psbm_ctrl #(.LATENCY_CLKS(2), .SLEEP_WAKE(20), .PDOWN_WAKE(30)) dut (
        .core_clk, .rst, .cs_n_pin, .ck_pin, .reset_n_pin, .dq_in,
        .dq_out, .dq_oe, .rwds_in, .rwds_out, .rwds_oe, .refresh_busy,
        .sleep_set, .pdown_set, .rd_data, .rd_req, .wr_valid, .wr_ready,
        .wr_data, .wr_mask, .wr_overrun, .ca_word, .ca_valid, .sleep_bit,
        .low_power, .refresh_en, .array_lost, .cfg_defaults,
        .clock_stop, .standby);
    psbm_host host (.core_clk, .cs_n_pin, .ck_pin, .h_dq, .h_rwds);

    ////////////////////////////////////////////////////////////////////
    // Clock of 20 ns.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Counts command words, dropped bytes and cycles; cuts a hang.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (ca_valid === 1'b1) n_ca <= n_ca + 1;
        if (wr_overrun === 1'b1) n_ovr <= n_ovr + 1;
        if (rd_req === 1'b1) n_rd <= n_rd + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one.
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("BAD at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Waits, bounded, for a pair of low-power and standby levels.
    task automatic wait_st(input logic [1:0] v, input int n);
        for (int i = 0; i < n && {low_power, standby} !== v; i++) w(1);
    endtask
    // Sends the six command bytes, first byte first.
    task automatic send_ca(input logic [47:0] cw);
        for (int i = 5; i >= 0; i--) begin
            host.edge_b(cw[i*8 +: 8], 1'b0, 1'b1, 1'b0);
        end
    endtask
    // Pops n bytes, expecting counting data, with the mask set on odd bytes when mk is set.
    task automatic drain(input int n, input logic mk);
        for (int i = 0; i < n; i++) begin
            chk({wr_valid, wr_data, wr_mask}, {1'b1, 8'(i), mk & i[0]});
            wr_ready <= 1'b1;
            w(1);
            wr_ready <= 1'b0;
            w(1);
        end
        chk(wr_valid, 1'b0);
    endtask
    task automatic end_sim();
        $display("%0d compared, %0d mismatches", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({dq_oe, rwds_oe, standby, cfg_defaults, array_lost}, 5'h07);
        rst <= 1'b0;
        w(6);
        chk({refresh_en, cfg_defaults}, 2'h2);
        $display("reset test done");
    endtask
    task automatic t_idle();
        int c;
        c = n_ca;
        repeat (4) host.edge_b(8'hFF, 1'b1, 1'b1, 1'b1);
        w(4);
        chk({standby, dq_oe, rwds_oe, n_ca == c}, 4'h9);
        $display("standby test done");
    endtask
    task automatic t_read();
        int r;
        r = n_rd;
        rd_data <= 8'h5A;
        host.sel();
        chk({rwds_oe, rwds_out}, 2'h2);
        send_ca(48'h8012_3456_789A);
        repeat (6) host.edge_b(8'h00, 1'b0, 1'b0, 1'b0);
        w(3);
        chk({dq_oe, dq_out}, 9'h15A);
        rd_data <= 8'h00;
        w(6);
        chk({clock_stop, dq_oe, dq_out}, 10'h35A);
        repeat (2) host.edge_b(8'h00, 1'b0, 1'b0, 1'b0);
        chk(clock_stop, 1'b0);
        host.desel();
        chk(dq_oe, 1'b0);
        chk(ca_word, 48'h8012_3456_789A);
        chk(n_rd - r, 4);
        $display("read test done");
    endtask
    task automatic t_write();
        int o;
        o = n_ovr;
        refresh_busy <= 1'b1;
        host.sel();
        chk({rwds_oe, rwds_out}, 2'h3);
        refresh_busy <= 1'b0;
        send_ca(48'h0000_0000_0010);
        repeat (4) host.edge_b(8'h00, 1'b0, 1'b0, 1'b0);
        chk({dq_oe, rwds_oe}, 2'h0);
        repeat (4) host.edge_b(8'h00, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 34; i++) host.edge_b(8'(i), i[0], 1'b1, 1'b1);
        host.desel();
        chk(n_ovr - o, 2);
        drain(32, 1'b1);
        $display("write test done");
    endtask
    task automatic t_zero();
        host.sel();
        send_ca(48'h4000_0000_0000);
        for (int i = 0; i < 2; i++) host.edge_b(8'(i), 1'b1, 1'b1, 1'b0);
        chk(rwds_oe, 1'b0);
        host.desel();
        drain(2, 1'b0);
        $display("zero latency test done");
    endtask
    task automatic t_sleep();
        int c;
        c = n_ca;
        sleep_set <= 1'b1;
        w(1);
        sleep_set <= 1'b0;
        wait_st(2'h2, 160);
        chk({low_power, sleep_bit, array_lost}, 3'h6);
        host.pulse(4);
        chk({sleep_bit, n_ca == c}, 2'h1);
        wait_st(2'h1, 40);
        chk({standby, array_lost}, 2'h2);
        $display("sleep test done");
    endtask
    task automatic t_pdown();
        pdown_set <= 1'b1;
        w(1);
        pdown_set <= 1'b0;
        wait_st(2'h2, 160);
        w(1);
        chk({low_power, refresh_en, array_lost}, 3'h5);
        host.pulse(12);
        for (int i = 0; i < 60 && cfg_defaults !== 1'b1; i++) w(1);
        chk(cfg_defaults, 1'b1);
        wait_st(2'h1, 4);
        chk(standby, 1'b1);
        $display("power-down test done");
    endtask
    task automatic t_hwrst();
        for (int k = 0; k < 2; k++) begin
            {pdown_set, sleep_set} <= (k == 1) ? 2'h2 : 2'h1;
            w(1);
            {pdown_set, sleep_set} <= 2'h0;
            wait_st(2'h2, 160);
            reset_n_pin <= 1'b0;
            w(4);
            reset_n_pin <= 1'b1;
            w(6);
            chk({low_power, sleep_bit, array_lost}, 3'h1);
        end
        $display("pin reset test done");
    endtask
    ////////////////////////////////////////////////////////////////////
    // Reset for four cycles, then every scenario in turn.
    initial begin
        {rst, reset_n_pin, refresh_busy} = 3'h6;
        {sleep_set, pdown_set, wr_ready} = 3'h0;
        rd_data = 8'h00;
        w(4);
        t_reset();
        t_idle();
        t_read();
        t_write();
        t_zero();
        t_sleep();
        t_pdown();
        t_hwrst();
        end_sim();
    end
endmodule
`default_nettype wire
